// File: rtl/timer2_capture_reload.sv
// What this block does
// - Count held as separately accessible high, low bytes
// - Timer function: one increment per machine cycle
// - Counter function: count falling edges on count pin
// - Sample pin at state5_phase2; high-then-low counts one
// - New count visible at state3_phase1, next cycle
// - Clock selects give baud; else capture bit picks
// - Select bit: 0 machine cycles, 1 pin edges
// - Overflow flag bit 7 set, software clears
// - No overflow flag while either clock select set
// - External flag bit 6 set on triggered capture/reload
// - External flag requests timer interrupt
// - Down-count enable masks external flag request
// - Capture copies count bytes into reload bytes
// - Auto-reload on overflow or enabled trigger edge
// - Baud generator counts every state time, or pin edges if select bit 1, reloads
// - Receive and transmit selects route ticks independently
`timescale 1ns/1ns
`default_nettype none

module timer2_capture_reload import timer2_pkg::*; (
   // Clock and reset
   input wire logic clock,
   input wire logic srst,
   // Special-function register port
   input wire sfr_req_t sfr_req,
   output logic [7:0] sfr_rdata,
   // External pins
   input wire logic count_input_pin,
   input wire logic capture_trigger_pin,
   // Interrupt request and serial clock ticks
   output logic timer_irq,
   output logic rx_baud_tick,
   output logic tx_baud_tick
);

   timer_state_t s;
   timer_state_t next_s;
   timer_mode_t mode;
   logic sample_strobe;
   logic update_strobe;
   logic state_strobe;
   logic run;
   logic inc;
   logic rollover;
   logic trig_edge;
   logic trig_hit;
   logic count_wr;
   logic reload_wr;
   logic ctrl_wr;
   logic set_overflow;
   logic set_external;

   machine_phase phase_gen (
      .clock(clock),
      .srst(srst),
      .sample_strobe(sample_strobe),
      .update_strobe(update_strobe),
      .state_strobe(state_strobe)
   );

   // ------------------------------------------------------------
   // Mode decode
   // ------------------------------------------------------------
   always_comb begin
      run = s.ctrl[RUN_BIT];
      if (!run) begin
         mode = MODE_OFF;
      end else if (s.ctrl[RX_CLOCK_BIT] || s.ctrl[TX_CLOCK_BIT]) begin
         mode = MODE_BAUD;
      end else if (s.ctrl[CAPTURE_SELECT_BIT]) begin
         mode = MODE_CAPTURE;
      end else begin
         mode = MODE_RELOAD;
      end
   end

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   always_comb begin
      next_s = s;
      ctrl_wr = sfr_req.write && (sfr_req.addr == CTRL_ADDR);
      count_wr = sfr_req.write && ((sfr_req.addr == COUNT_LOW_ADDR) ||
                                   (sfr_req.addr == COUNT_HIGH_ADDR));
      reload_wr = sfr_req.write && ((sfr_req.addr == RELOAD_LOW_ADDR) ||
                                    (sfr_req.addr == RELOAD_HIGH_ADDR));
      // Pins pass two flip-flops before anything reads them
      next_s.pin_meta = count_input_pin;
      next_s.pin_sync = s.pin_meta;
      next_s.trig_meta = capture_trigger_pin;
      next_s.trig_sync = s.trig_meta;

      // Once-per-cycle sampling of both pins
      trig_edge = 1'b0;
      if (sample_strobe) begin
         next_s.pin_prev = s.pin_sync;
         next_s.trig_prev = s.trig_sync;
         if (s.pin_prev && !s.pin_sync) begin
            next_s.pin_pending = 1'b1;
         end
         trig_edge = s.trig_prev && !s.trig_sync;
      end
      trig_hit = trig_edge && s.ctrl[EXT_ENABLE_BIT] && run;

      // Increment source
      inc = 1'b0;
      if (update_strobe) begin
         next_s.pin_pending = 1'b0;
      end
      if (s.ctrl[COUNTER_SELECT_BIT]) begin
         inc = update_strobe && s.pin_pending && run;
      end else if (mode == MODE_BAUD) begin
         inc = state_strobe;
      end else begin
         inc = update_strobe && run;
      end
      rollover = inc && (s.count == COUNT_MAX);

      // Count, capture and reload
      set_overflow = 1'b0;
      set_external = trig_hit;
      next_s.rx_tick = 1'b0;
      next_s.tx_tick = 1'b0;
      if (inc) begin
         next_s.count = 16'(s.count + 16'h1);
      end
      case (mode)
         MODE_CAPTURE: begin
            set_overflow = rollover;
            if (trig_hit) begin
               next_s.reload = s.count;
            end
         end
         MODE_RELOAD: begin
            set_overflow = rollover;
            if (rollover || trig_hit) begin
               next_s.count = s.reload;
            end
         end
         MODE_BAUD: begin
            // Trigger edge only raises the flag here, no reload
            if (rollover) begin
               next_s.count = s.reload;
               next_s.rx_tick = s.ctrl[RX_CLOCK_BIT];
               next_s.tx_tick = s.ctrl[TX_CLOCK_BIT];
            end
         end
         default: begin
            next_s.count = s.count;
         end
      endcase

      // Software access, flags set by hardware win over a clear
      if (ctrl_wr) begin
         next_s.ctrl = sfr_req.wdata;
      end
      if (set_overflow) begin
         next_s.ctrl[OVERFLOW_BIT] = 1'b1;
      end
      if (set_external) begin
         next_s.ctrl[EXTERNAL_BIT] = 1'b1;
      end
      if (sfr_req.write) begin
         case (sfr_req.addr)
            MODE_ADDR: next_s.down_count_enable = sfr_req.wdata[DOWN_COUNT_BIT];
            RELOAD_LOW_ADDR: next_s.reload[7:0] = sfr_req.wdata;
            RELOAD_HIGH_ADDR: next_s.reload[15:8] = sfr_req.wdata;
            COUNT_LOW_ADDR: next_s.count[7:0] = sfr_req.wdata;
            COUNT_HIGH_ADDR: next_s.count[15:8] = sfr_req.wdata;
            default: next_s.down_count_enable = next_s.down_count_enable;
         endcase
      end
      if (sfr_req.read) begin
         case (sfr_req.addr)
            CTRL_ADDR: next_s.rdata = s.ctrl;
            MODE_ADDR: next_s.rdata = {7'h00, s.down_count_enable};
            RELOAD_LOW_ADDR: next_s.rdata = s.reload[7:0];
            RELOAD_HIGH_ADDR: next_s.rdata = s.reload[15:8];
            COUNT_LOW_ADDR: next_s.rdata = s.count[7:0];
            COUNT_HIGH_ADDR: next_s.rdata = s.count[15:8];
            default: next_s.rdata = UNMAPPED_DATA;
         endcase
      end

      // Interrupt request
      next_s.irq = next_s.ctrl[OVERFLOW_BIT] ||
                   (next_s.ctrl[EXTERNAL_BIT] && !next_s.down_count_enable);
   end

   // ------------------------------------------------------------
   // State register
   // ------------------------------------------------------------
   always_ff @(posedge clock) begin
      if (srst) begin
         s <= '0;
         s.ctrl <= CTRL_RESET;
         s.down_count_enable <= MODE_RESET;
         s.count <= COUNT_RESET;
         s.reload <= COUNT_RESET;
      end else begin
         s <= next_s;
      end
   end

   assign sfr_rdata = s.rdata;
   assign timer_irq = s.irq;
   assign rx_baud_tick = s.rx_tick;
   assign tx_baud_tick = s.tx_tick;

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (srst);

   property p_low_byte_read;
      (sfr_req.read && sfr_req.addr == COUNT_LOW_ADDR)
         |=> sfr_rdata == $past(s.count[7:0]);
   endproperty
   a_low_byte_read: assert property (p_low_byte_read)
      else $error("count low byte read wrong");

   property p_timer_inc;
      (!s.ctrl[COUNTER_SELECT_BIT] && run && mode != MODE_BAUD &&
       update_strobe && s.count != COUNT_MAX && !trig_hit && !count_wr)
         |=> s.count == 16'($past(s.count) + 16'h1);
   endproperty
   a_timer_inc: assert property (p_timer_inc)
      else $error("timer did not increment at machine cycle");

   property p_timer_hold;
      (!s.ctrl[COUNTER_SELECT_BIT] && mode != MODE_BAUD && !update_strobe &&
       !trig_hit && !count_wr) |=> $stable(s.count);
   endproperty
   a_timer_hold: assert property (p_timer_hold)
      else $error("timer moved outside update phase");

   property p_counter_no_edge;
      (s.ctrl[COUNTER_SELECT_BIT] && !s.pin_pending && !trig_hit &&
       !count_wr) |=> $stable(s.count);
   endproperty
   a_counter_no_edge: assert property (p_counter_no_edge)
      else $error("counter moved without a pin edge");

   property p_edge_detect;
      (sample_strobe && s.pin_prev && !s.pin_sync) |=> s.pin_pending;
   endproperty
   a_edge_detect: assert property (p_edge_detect)
      else $error("falling edge on count pin missed");

   property p_edge_count;
      (s.ctrl[COUNTER_SELECT_BIT] && run && update_strobe && s.pin_pending &&
       s.count != COUNT_MAX && !trig_hit && !count_wr)
         |=> s.count == 16'($past(s.count) + 16'h1) && !s.pin_pending;
   endproperty
   a_edge_count: assert property (p_edge_count)
      else $error("edge not counted at update phase");

   property p_mode_baud;
      (run && (s.ctrl[RX_CLOCK_BIT] || s.ctrl[TX_CLOCK_BIT]) && trig_hit &&
       !inc && !count_wr) |=> $stable(s.count);
   endproperty
   a_mode_baud: assert property (p_mode_baud)
      else $error("clock select did not pick baud mode");

   property p_off_hold;
      (!run && !count_wr) |=> $stable(s.count);
   endproperty
   a_off_hold: assert property (p_off_hold)
      else $error("count changed while stopped");

   property p_overflow_set;
      (rollover && mode != MODE_BAUD) |=> s.ctrl[OVERFLOW_BIT];
   endproperty
   a_overflow_set: assert property (p_overflow_set)
      else $error("overflow flag not set");

   property p_overflow_sticky;
      (s.ctrl[OVERFLOW_BIT] && !ctrl_wr) |=> s.ctrl[OVERFLOW_BIT];
   endproperty
   a_overflow_sticky: assert property (p_overflow_sticky)
      else $error("overflow flag cleared by hardware");

   property p_baud_no_flag;
      (mode == MODE_BAUD && !ctrl_wr)
         |=> s.ctrl[OVERFLOW_BIT] == $past(s.ctrl[OVERFLOW_BIT]);
   endproperty
   a_baud_no_flag: assert property (p_baud_no_flag)
      else $error("overflow flag changed in baud mode");

   property p_external_set;
      trig_hit |=> s.ctrl[EXTERNAL_BIT];
   endproperty
   a_external_set: assert property (p_external_set)
      else $error("external flag not set on trigger");

   property p_irq;
      timer_irq == (s.ctrl[OVERFLOW_BIT] ||
                    (s.ctrl[EXTERNAL_BIT] && !s.down_count_enable));
   endproperty
   a_irq: assert property (p_irq)
      else $error("interrupt request does not match flags");

   property p_capture;
      (trig_hit && mode == MODE_CAPTURE && !reload_wr)
         |=> s.reload == $past(s.count);
   endproperty
   a_capture: assert property (p_capture)
      else $error("capture did not copy count");

   property p_reload;
      ((rollover || trig_hit) && mode == MODE_RELOAD && !count_wr)
         |=> s.count == $past(s.reload);
   endproperty
   a_reload: assert property (p_reload)
      else $error("auto-reload did not load count");

   property p_baud_inc;
      (mode == MODE_BAUD && !s.ctrl[COUNTER_SELECT_BIT] && state_strobe &&
       s.count != COUNT_MAX && !count_wr)
         |=> s.count == 16'($past(s.count) + 16'h1);
   endproperty
   a_baud_inc: assert property (p_baud_inc)
      else $error("baud generator missed a state time");

   property p_baud_ticks;
      (rollover && mode == MODE_BAUD)
         |=> rx_baud_tick == $past(s.ctrl[RX_CLOCK_BIT]) &&
             tx_baud_tick == $past(s.ctrl[TX_CLOCK_BIT]) ##1
             !rx_baud_tick && !tx_baud_tick;
   endproperty
   a_baud_ticks: assert property (p_baud_ticks)
      else $error("baud ticks misrouted");

   c_capture: cover property (trig_hit && mode == MODE_CAPTURE);
   c_reload: cover property (rollover && mode == MODE_RELOAD);
   c_baud: cover property (rollover && mode == MODE_BAUD);
   c_edge: cover property (s.pin_pending ##[1:12] update_strobe);

endmodule // timer2_capture_reload

`default_nettype wire

// File: rtl/timer2_pkg.sv
package timer2_pkg;

   // ------------------------------------------------------------
   // Register map
   // ------------------------------------------------------------
   localparam logic [7:0] CTRL_ADDR = 8'hc8;
   localparam logic [7:0] MODE_ADDR = 8'hc9;
   localparam logic [7:0] RELOAD_LOW_ADDR = 8'hca;
   localparam logic [7:0] RELOAD_HIGH_ADDR = 8'hcb;
   localparam logic [7:0] COUNT_LOW_ADDR = 8'hcc;
   localparam logic [7:0] COUNT_HIGH_ADDR = 8'hcd;
   localparam logic [7:0] UNMAPPED_DATA = 8'h00;

   // ------------------------------------------------------------
   // Control register fields and reset values
   // ------------------------------------------------------------
   localparam int OVERFLOW_BIT = 7;
   localparam int EXTERNAL_BIT = 6;
   localparam int RX_CLOCK_BIT = 5;
   localparam int TX_CLOCK_BIT = 4;
   localparam int EXT_ENABLE_BIT = 3;
   localparam int RUN_BIT = 2;
   localparam int COUNTER_SELECT_BIT = 1;
   localparam int CAPTURE_SELECT_BIT = 0;
   localparam int DOWN_COUNT_BIT = 0;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic MODE_RESET = 1'b0;
   localparam logic [15:0] COUNT_RESET = 16'h0000;
   localparam logic [15:0] COUNT_MAX = 16'hffff;

   // ------------------------------------------------------------
   // Machine cycle timing, one clock per oscillator period
   // ------------------------------------------------------------
   localparam int OSC_PER_MACHINE_CYCLE = 12;
   localparam logic [3:0] LAST_PHASE = 4'(OSC_PER_MACHINE_CYCLE - 1);
   // Phase index is (state - 1) * 2 + (phase - 1)
   localparam logic [3:0] STATE5_PHASE2 = 4'h9;
   localparam logic [3:0] STATE3_PHASE1 = 4'h4;

   // ------------------------------------------------------------
   // Types
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      MODE_OFF = 2'b00,
      MODE_RELOAD = 2'b01,
      MODE_CAPTURE = 2'b11,
      MODE_BAUD = 2'b10
   } timer_mode_t;

   typedef struct packed {
      logic write;
      logic read;
      logic [7:0] addr;
      logic [7:0] wdata;
   } sfr_req_t;

   typedef struct packed {
      logic [7:0] ctrl;
      logic down_count_enable;
      logic [15:0] count;
      logic [15:0] reload;
      logic pin_meta;
      logic pin_sync;
      logic trig_meta;
      logic trig_sync;
      logic pin_prev;
      logic trig_prev;
      logic pin_pending;
      logic [7:0] rdata;
      logic irq;
      logic rx_tick;
      logic tx_tick;
   } timer_state_t;

endpackage

// File: rtl/machine_phase.sv
`timescale 1ns/1ns
`default_nettype none

module machine_phase import timer2_pkg::*; (
   // Clock and reset
   input wire logic clock,
   input wire logic srst,
   // Phase strobes
   output logic sample_strobe,
   output logic update_strobe,
   output logic state_strobe
);

   logic [3:0] phase;
   logic [3:0] next_phase;

   // ------------------------------------------------------------
   // Twelve-period machine cycle
   // ------------------------------------------------------------
   always_comb begin
      next_phase = (phase == LAST_PHASE) ? 4'h0 : 4'(phase + 4'h1);
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         phase <= 4'h0;
      end else begin
         phase <= next_phase;
      end
   end

   assign sample_strobe = (phase == STATE5_PHASE2);
   assign update_strobe = (phase == STATE3_PHASE1);
   // Phase 2 of every state ends a state time
   assign state_strobe = phase[0];

endmodule // machine_phase

`default_nettype wire

// File: dv/ext_pin_source.sv
`timescale 1ns/1ns
`default_nettype none

module ext_pin_source (
   // Clock
   input wire logic clock,
   // Pins toward the timer
   output logic count_input_pin,
   output logic capture_trigger_pin
);
   // Each level outlasts one machine cycle so it is always sampled
   localparam int HOLD = 18;

   // ------------------------------------------------------------
   // Idle level
   // ------------------------------------------------------------
   initial begin
      count_input_pin = 1'b1;
      capture_trigger_pin = 1'b1;
   end

   // ------------------------------------------------------------
   // Pulse generators, entered and left at a falling edge
   // ------------------------------------------------------------
   task automatic pulse_count(input int n);
      for (int i = 0; i < n; i++) begin
         @(negedge clock);
         count_input_pin = 1'b0;
         repeat (HOLD) @(negedge clock);
         count_input_pin = 1'b1;
         repeat (HOLD - 1) @(negedge clock);
      end
   endtask

   task automatic pulse_trigger();
      @(negedge clock);
      capture_trigger_pin = 1'b0;
      repeat (HOLD) @(negedge clock);
      capture_trigger_pin = 1'b1;
      repeat (HOLD - 1) @(negedge clock);
   endtask

endmodule // ext_pin_source

`default_nettype wire

// File: dv/timer2_capture_reload_tb.sv
`timescale 1ns/1ns
`default_nettype none

module timer2_capture_reload_tb import timer2_pkg::*; ;
   logic clock = 1'b0;
   logic srst = 1'b1;
   sfr_req_t sfr_req = '0;
   logic [7:0] sfr_rdata;
   logic count_input_pin;
   logic capture_trigger_pin;
   logic timer_irq;
   logic rx_baud_tick;
   logic tx_baud_tick;
   int n_fail = 0;
   int checked = 0;
   int n_rx = 0;
   int n_tx = 0;

   always #5 clock = ~clock;

   timer2_capture_reload u_dut (
      .clock(clock),
      .srst(srst),
      .sfr_req(sfr_req),
      .sfr_rdata(sfr_rdata),
      .count_input_pin(count_input_pin),
      .capture_trigger_pin(capture_trigger_pin),
      .timer_irq(timer_irq),
      .rx_baud_tick(rx_baud_tick),
      .tx_baud_tick(tx_baud_tick)
   );

   ext_pin_source u_pins (
      .clock(clock),
      .count_input_pin(count_input_pin),
      .capture_trigger_pin(capture_trigger_pin)
   );

   always @(negedge clock) begin
      if (rx_baud_tick === 1'b1)
         n_rx++;
      if (tx_baud_tick === 1'b1)
         n_tx++;
   end

   // ------------------------------------------------------------
   // Checking and register access, entered at a falling edge
   // ------------------------------------------------------------
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         n_fail++;
         $display("CHECK FAILED at %0t: saw %h, expected %h", $time, seen,
            exp);
      end
   endtask

   task automatic wr(input logic [7:0] addr, input logic [7:0] data);
      sfr_req = '{write: 1'b1, read: 1'b0, addr: addr, wdata: data};
      @(negedge clock);
      sfr_req.write = 1'b0;
      @(negedge clock);
   endtask

   task automatic rd8(input logic [7:0] addr, output logic [7:0] data);
      sfr_req = '{write: 1'b0, read: 1'b1, addr: addr, wdata: 8'h00};
      @(negedge clock);
      sfr_req.read = 1'b0;
      @(negedge clock);
      data = sfr_rdata;
   endtask

   task automatic wr16(input logic [7:0] lo_addr, input logic [15:0] v);
      wr(lo_addr, v[7:0]);
      wr(lo_addr + 8'h01, v[15:8]);
   endtask

   task automatic expect8(input logic [7:0] addr, input logic [7:0] exp);
      logic [7:0] v;
      rd8(addr, v);
      check({8'h00, v}, {8'h00, exp});
   endtask

   task automatic expect16(input logic [7:0] lo_addr,
         input logic [15:0] exp);
      logic [7:0] lo;
      logic [7:0] hi;
      rd8(lo_addr, lo);
      rd8(lo_addr + 8'h01, hi);
      check({hi, lo}, exp);
   endtask

   // Runs the timer for exactly k machine cycles, then stops it
   task automatic run_case(input logic [7:0] ctrl, input logic [15:0] start,
         input logic [15:0] reload, input int k, input logic [15:0] exp_cnt,
         input logic [7:0] exp_ctrl, input logic exp_irq,
         input logic [15:0] exp_ticks);
      logic [7:0] seen_ctrl;
      logic seen_irq;
      wr16(RELOAD_LOW_ADDR, reload);
      wr16(COUNT_LOW_ADDR, start);
      n_rx = 0;
      n_tx = 0;
      wr(CTRL_ADDR, ctrl);
      repeat (12 * k - 4) @(negedge clock);
      seen_irq = timer_irq;
      rd8(CTRL_ADDR, seen_ctrl);
      wr(CTRL_ADDR, 8'h00);
      expect16(COUNT_LOW_ADDR, exp_cnt);
      check({8'h00, seen_ctrl}, {8'h00, exp_ctrl});
      check({15'h0000, seen_irq}, {15'h0000, exp_irq});
      check({n_rx[7:0], n_tx[7:0]}, exp_ticks);
   endtask

   task automatic tally_and_finish;
      $display("comparisons %0d, mismatches %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   // ------------------------------------------------------------
   // Tests
   // ------------------------------------------------------------
   initial begin
      #200000;
      n_fail++;
      $display("watchdog expired at %0t", $time);
      tally_and_finish();
   end

   initial begin
      repeat (6) @(posedge clock);
      @(negedge clock);
      srst = 1'b0;
      @(negedge clock);
      expect8(CTRL_ADDR, CTRL_RESET);
      expect8(MODE_ADDR, 8'h00);
      expect16(COUNT_LOW_ADDR, COUNT_RESET);
      expect16(RELOAD_LOW_ADDR, 16'h0000);
      expect8(8'hc7, UNMAPPED_DATA);
      wr(CTRL_ADDR, 8'h3a);
      expect8(CTRL_ADDR, 8'h3a);
      wr(CTRL_ADDR, 8'h00);
      $display("test registers done");

      run_case(8'h04, 16'h00ff, 16'h0000, 1, 16'h0100, 8'h04, 1'b0,
         16'h0000);
      run_case(8'h04, 16'hfffe, 16'h1234, 3, 16'h1235, 8'h84, 1'b1,
         16'h0000);
      run_case(8'h05, 16'hfffe, 16'h1234, 3, 16'h0001, 8'h85, 1'b1,
         16'h0000);
      run_case(8'h14, 16'hfffd, 16'habcd, 1, 16'habd0, 8'h14, 1'b0,
         16'h0001);
      run_case(8'h25, 16'hfffd, 16'habcd, 1, 16'habd0, 8'h25, 1'b0,
         16'h0100);
      run_case(8'h00, 16'h4321, 16'h0000, 2, 16'h4321, 8'h00, 1'b0,
         16'h0000);
      $display("test timer modes done");

      wr16(COUNT_LOW_ADDR, 16'h0000);
      wr(CTRL_ADDR, 8'h06);
      u_pins.pulse_count(5);
      repeat (40) @(negedge clock);
      wr(CTRL_ADDR, 8'h00);
      expect16(COUNT_LOW_ADDR, 16'h0005);
      u_pins.pulse_count(2);
      repeat (40) @(negedge clock);
      expect16(COUNT_LOW_ADDR, 16'h0005);
      $display("test event counter done");

      wr16(COUNT_LOW_ADDR, 16'h5a3c);
      wr16(RELOAD_LOW_ADDR, 16'h0000);
      wr(CTRL_ADDR, 8'h0f);
      u_pins.pulse_trigger();
      repeat (30) @(negedge clock);
      expect8(CTRL_ADDR, 8'h4f);
      check({15'h0000, timer_irq}, 16'h0001);
      wr(MODE_ADDR, 8'h01);
      repeat (4) @(negedge clock);
      check({15'h0000, timer_irq}, 16'h0000);
      wr(MODE_ADDR, 8'h00);
      repeat (4) @(negedge clock);
      check({15'h0000, timer_irq}, 16'h0001);
      wr(CTRL_ADDR, 8'h00);
      expect16(RELOAD_LOW_ADDR, 16'h5a3c);
      expect16(COUNT_LOW_ADDR, 16'h5a3c);
      $display("test capture done");

      wr16(COUNT_LOW_ADDR, 16'h0001);
      wr16(RELOAD_LOW_ADDR, 16'h7788);
      wr(CTRL_ADDR, 8'h0e);
      u_pins.pulse_trigger();
      repeat (30) @(negedge clock);
      expect8(CTRL_ADDR, 8'h4e);
      wr(CTRL_ADDR, 8'h00);
      expect16(COUNT_LOW_ADDR, 16'h7788);
      expect8(CTRL_ADDR, 8'h00);
      $display("test triggered reload done");

      // Baud mode on pin edges: the trigger only raises the flag
      wr16(COUNT_LOW_ADDR, 16'h2468);
      wr16(RELOAD_LOW_ADDR, 16'h1357);
      wr(CTRL_ADDR, 8'h1e);
      u_pins.pulse_trigger();
      repeat (30) @(negedge clock);
      expect8(CTRL_ADDR, 8'h5e);
      check({15'h0000, timer_irq}, 16'h0001);
      wr(CTRL_ADDR, 8'h00);
      expect16(COUNT_LOW_ADDR, 16'h2468);
      $display("test baud trigger done");
      tally_and_finish();
   end

endmodule // timer2_capture_reload_tb

`default_nettype wire
